//--- logic/tcc_channel.v
// One comparator channel: input routing, result shaping and event detection
`include "tcc_defs.vh"

module tcc_channel (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       clk_en,
  // Configuration
  input  wire       comparator_on,
  input  wire       halted,
  input  wire       pin_drive_enable,
  input  wire       result_invert,
  input  wire [1:0] event_edge_select,
  input  wire       noninv_source_select,
  input  wire [1:0] inv_channel_select,
  input  wire [1:0] internal_ref_source,
  input  wire       event_clear,
  // Analog decision per candidate pairing: bit index = {noninv_sel, inv_code}
  input  wire [7:0] raw_decision,
  // Results
  output wire [2:0] route_sel,
  output wire       result_pin,
  output wire       result_pin_oe,
  output reg        result_level_q,
  output reg        event_flag_q,
  output wire       event_pulse
);

  reg        sync1_q;
  reg        sync2_q;
  reg        prev_q;
  wire       active;
  wire       raw_sel;
  wire       adj_raw;
  reg        hit;

  // The analog mux select picks the pairing seen by the comparator
  assign route_sel = {noninv_source_select, inv_channel_select};
  assign active    = comparator_on & ~halted;
  assign raw_sel   = raw_decision[route_sel];
  assign adj_raw   = (raw_sel ^ result_invert) & active;

  // Pin sees the unsynchronized result, no clock in the path
  assign result_pin    = adj_raw;
  assign result_pin_oe = pin_drive_enable;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
      result_level_q <= 1'b0;
    end else if (clk_en) begin
      sync1_q <= adj_raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      result_level_q <= sync2_q;
    end
  end

  always @* begin
    case (event_edge_select)
      `TCC_EV_RISE: hit = sync2_q & ~prev_q;
      `TCC_EV_FALL: hit = ~sync2_q & prev_q;
      `TCC_EV_ANY:  hit = sync2_q ^ prev_q;
      default:      hit = 1'b0;
    endcase
  end

  // Flag blocks further triggers; a hit in the same cycle as a clear of the set flag is dropped
  assign event_pulse = hit & active & ~event_flag_q & clk_en;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      event_flag_q <= 1'b0;
    else if (clk_en) begin
      if (event_pulse)
        event_flag_q <= 1'b1;
      else if (event_clear)
        event_flag_q <= 1'b0;
    end
  end

  // Reference source only matters when channel select is 11
  wire unused_ref = |internal_ref_source;
endmodule

//--- logic/tcc_defs.vh
// Register map, field positions and codes of the triple comparator control block
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// Word byte addresses
`define TCC_ADDR_CTRL1      8'h00
`define TCC_ADDR_CTRL2      8'h04
`define TCC_ADDR_CTRL3      8'h08
`define TCC_ADDR_STAT       8'h0C
`define TCC_ADDR_IRQ_STAT   8'h10
`define TCC_ADDR_IRQ_MASK   8'h14
`define TCC_ADDR_REFSRC     8'h18

// Control register fields
`define TCC_CTL_ON          15
`define TCC_CTL_PINEN       14
`define TCC_CTL_INV         13
`define TCC_CTL_EVT         9
`define TCC_CTL_OUT         8
`define TCC_CTL_EDGE_HI     7
`define TCC_CTL_EDGE_LO     6
`define TCC_CTL_NISRC       4
`define TCC_CTL_CH_HI       1
`define TCC_CTL_CH_LO       0
// Writable bits of a control register
`define TCC_CTL_WMASK       16'hE0D3

// Status register fields
`define TCC_ST_IDLE         15
`define TCC_ST_EVT_LO       8
`define TCC_ST_OUT_LO       0

// Event select codes
`define TCC_EV_NONE         2'b00
`define TCC_EV_RISE         2'b01
`define TCC_EV_FALL         2'b10
`define TCC_EV_ANY          2'b11

// Inverting input channel codes
`define TCC_CH_B            2'b00
`define TCC_CH_C            2'b01
`define TCC_CH_D            2'b10
`define TCC_CH_REF          2'b11

// Internal reference source codes
`define TCC_RS_BG           2'b00
`define TCC_RS_BG2          2'b01
`define TCC_RS_BG6          2'b10
`define TCC_RS_VREFP        2'b11

// AHB constants
`define TCC_HTRANS_NONSEQ_B 1
`define TCC_RESET_16        16'h0000
`define TCC_RESET_32        32'h0000_0000
`define TCC_IDX_W           8
`endif

//--- logic/tcc_top.v
// Triple comparator control: AHB-Lite registers, routing and events for three comparators
// Contract
// - Each comparator picks external or internal references
// - Three control registers, one shared status register
// - Output-enable drives raw result onto pin
// - Event flag set, blocks triggers until cleared
// - Reference bit routes non-inverting input
// - Channel field routes inverting input
// - Stop-in-idle bit halts all comparators
// - Status shows event copies at bits 10:8
// - Status shows result copies at bits 2:0
// - Unimplemented bits read zero, ignore writes
// - Reference-source field chooses internal reference
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`include "tcc_defs.vh"

module tcc_top #(
  parameter NCMP = 3
) (
  // Clock, reset, enable
  input  wire              hclk,
  input  wire              hresetn,
  input  wire              clk_en,
  // AHB-Lite slave
  input  wire              hsel,
  input  wire [7:0]        haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output wire [31:0]       hrdata,
  output wire              hreadyout,
  output wire              hresp,
  // Device state
  input  wire              idle_mode,
  // Comparator decisions, 8 pairings per comparator
  input  wire [8*NCMP-1:0] raw_decision,
  // Analog routing selects and internal reference source
  output wire [3*NCMP-1:0] route_sel,
  output wire [1:0]        internal_ref_source,
  output wire [NCMP-1:0]   comparator_on,
  // Pins
  output wire [NCMP-1:0]   result_pin,
  output wire [NCMP-1:0]   result_pin_oe,
  // Interrupt
  output wire              irq
);

  reg  [15:0]     ctrl_q [0:NCMP-1];
  reg             idle_halt_all_q;
  reg  [1:0]      ref_src_q;
  reg  [NCMP-1:0] irq_stat_q;
  reg  [NCMP-1:0] irq_mask_q;
  reg             idle_s1_q;
  reg             idle_s2_q;
  reg             wr_pend_q;
  reg  [7:0]      wr_addr_q;
  reg  [31:0]     rdata_q;
  wire [NCMP-1:0] evt_flag;
  wire [NCMP-1:0] res_lvl;
  wire [NCMP-1:0] evt_pulse;
  wire [NCMP-1:0] evt_clr;
  wire            halted;
  wire            acc;
  wire [15:0]     stat_word;
  wire [31:0]     ctl_word0;
  wire [31:0]     ctl_word1;
  wire [31:0]     ctl_word2;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign acc = hsel & hready & htrans[`TCC_HTRANS_NONSEQ_B] & clk_en;
  assign internal_ref_source = ref_src_q;

  // Idle comes from the system clock controller, kept synchronised
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_s1_q <= 1'b0;
      idle_s2_q <= 1'b0;
    end else if (clk_en) begin
      idle_s1_q <= idle_mode;
      idle_s2_q <= idle_s1_q;
    end
  end
  assign halted = idle_halt_all_q & idle_s2_q;

  // Event flag clears when software writes 0 to its control bit
  wire [15:0] wr_word = hwdata[15:0];
  wire        wr_now  = wr_pend_q & clk_en;

  genvar g;
  generate
    for (g = 0; g < NCMP; g = g + 1) begin : g_cmp
      // Control registers sit one word apart; only the low address byte is decoded
      localparam integer CTRL_OFF = `TCC_ADDR_CTRL1 + (`TCC_ADDR_CTRL2 - `TCC_ADDR_CTRL1) * g;
      wire sel_me = wr_now & (wr_addr_q == CTRL_OFF[7:0]);
      assign evt_clr[g] = sel_me & ~wr_word[`TCC_CTL_EVT];
      assign comparator_on[g] = ctrl_q[g][`TCC_CTL_ON];

      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
          ctrl_q[g] <= `TCC_RESET_16;
        else if (clk_en && sel_me)
          ctrl_q[g] <= wr_word & `TCC_CTL_WMASK;
      end

      tcc_channel u_ch (
        .hclk                 (hclk),
        .hresetn              (hresetn),
        .clk_en               (clk_en),
        .comparator_on        (ctrl_q[g][`TCC_CTL_ON]),
        .halted               (halted),
        .pin_drive_enable     (ctrl_q[g][`TCC_CTL_PINEN]),
        .result_invert        (ctrl_q[g][`TCC_CTL_INV]),
        .event_edge_select    (ctrl_q[g][`TCC_CTL_EDGE_HI:`TCC_CTL_EDGE_LO]),
        .noninv_source_select (ctrl_q[g][`TCC_CTL_NISRC]),
        .inv_channel_select   (ctrl_q[g][`TCC_CTL_CH_HI:`TCC_CTL_CH_LO]),
        .internal_ref_source  (ref_src_q),
        .event_clear          (evt_clr[g]),
        .raw_decision         (raw_decision[8*g+7:8*g]),
        .route_sel            (route_sel[3*g+2:3*g]),
        .result_pin           (result_pin[g]),
        .result_pin_oe        (result_pin_oe[g]),
        .result_level_q       (res_lvl[g]),
        .event_flag_q         (evt_flag[g]),
        .event_pulse          (evt_pulse[g])
      );

      // Sticky interrupt status, set wins over write-one-to-clear
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
          irq_stat_q[g] <= 1'b0;
        else if (clk_en) begin
          if (evt_pulse[g])
            irq_stat_q[g] <= 1'b1;
          else if (wr_now && wr_addr_q == `TCC_ADDR_IRQ_STAT && wr_word[g])
            irq_stat_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(irq_stat_q & irq_mask_q);

  // Shared status: event and result copies are read-only
  assign stat_word = {idle_halt_all_q, 4'h0, evt_flag[2:0], 5'h00, res_lvl[2:0]};

  // Control read view folds in live event flag and result
  function [31:0] ctl_view;
    input [15:0] c;
    input        e;
    input        o;
    reg   [15:0] v;
    begin
      v = c & `TCC_CTL_WMASK;
      v[`TCC_CTL_EVT] = e;
      v[`TCC_CTL_OUT] = o;
      ctl_view = {16'h0000, v};
    end
  endfunction

  assign ctl_word0 = ctl_view(ctrl_q[0], evt_flag[0], res_lvl[0]);
  assign ctl_word1 = ctl_view(ctrl_q[1], evt_flag[1], res_lvl[1]);
  assign ctl_word2 = ctl_view(ctrl_q[2], evt_flag[2], res_lvl[2]);

  // Address phase capture and read data registered for the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q   <= `TCC_RESET_32;
    end else if (clk_en) begin
      wr_pend_q <= acc & hwrite;
      wr_addr_q <= haddr;
      if (acc && !hwrite) begin
        case (haddr)
          `TCC_ADDR_CTRL1:    rdata_q <= ctl_word0;
          `TCC_ADDR_CTRL2:    rdata_q <= ctl_word1;
          `TCC_ADDR_CTRL3:    rdata_q <= ctl_word2;
          `TCC_ADDR_STAT:     rdata_q <= {16'h0000, stat_word};
          `TCC_ADDR_IRQ_STAT: rdata_q <= {29'h0000_0000, irq_stat_q[2:0]};
          `TCC_ADDR_IRQ_MASK: rdata_q <= {29'h0000_0000, irq_mask_q[2:0]};
          `TCC_ADDR_REFSRC:   rdata_q <= {30'h0000_0000, ref_src_q};
          default:            rdata_q <= `TCC_RESET_32;
        endcase
      end
    end
  end

  // Shared writable registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_halt_all_q <= 1'b0;
      irq_mask_q      <= {NCMP{1'b0}};
      ref_src_q       <= `TCC_RS_BG;
    end else if (wr_now) begin
      if (wr_addr_q == `TCC_ADDR_STAT)
        idle_halt_all_q <= wr_word[`TCC_ST_IDLE];
      if (wr_addr_q == `TCC_ADDR_IRQ_MASK)
        irq_mask_q <= wr_word[NCMP-1:0];
      if (wr_addr_q == `TCC_ADDR_REFSRC)
        ref_src_q <= wr_word[1:0];
    end
  end

  wire unused = |hsize | |hwdata[31:16];
endmodule

//--- tb/tcc_analog_model.sv
// Far-side model: analog decision of every input pairing of each comparator
module tcc_analog_model (
  // Levels per pairing, set by the bench
  input  wire [23:0] level,
  // Decisions towards the block
  output wire [23:0] raw_decision
);
  timeunit 1ns;
  timeprecision 1ns;
  // Settles at once; analog delay is not modelled
  assign raw_decision = level;
endmodule

//--- tb/tcc_top_monitor.sv
// Port-level assertions for the comparator control block
module tcc_monitor #(
  parameter NCMP = 3
) (
  // Clock and bus
  input wire              hclk,
  input wire              hresetn,
  input wire              clk_en,
  input wire              hsel,
  input wire [7:0]        haddr,
  input wire [1:0]        htrans,
  input wire              hwrite,
  input wire              hready,
  input wire [31:0]       hrdata,
  input wire              hreadyout,
  input wire              hresp,
  // Routing and pins
  input wire [3*NCMP-1:0] route_sel,
  input wire [1:0]        internal_ref_source,
  input wire [NCMP-1:0]   comparator_on,
  input wire [NCMP-1:0]   result_pin,
  input wire [NCMP-1:0]   result_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire  take = hsel && hready && htrans[1] && clk_en;
  logic wr_q;
  // Marks a write data phase, so register outputs may change at its end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      wr_q <= 1'b0;
    else
      wr_q <= take && hwrite;
  end
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer is not zero-wait OKAY");
  a_pin_gated_off: assert property ((result_pin & ~comparator_on) == '0)
    else $error("pin high while comparator off");
  a_oe_by_write: assert property ($changed(result_pin_oe) |-> $past(wr_q))
    else $error("pin enable changed without a write");
  a_route_by_write: assert property (!$past(wr_q) |-> $stable(route_sel))
    else $error("routing changed without a write");
  a_on_by_write: assert property ($changed(comparator_on) |-> $past(wr_q))
    else $error("enable changed without a write");
  a_refsrc_frozen: assert property (!clk_en |=> $stable(internal_ref_source))
    else $error("reference source moved while frozen");
  a_unmapped_zero: assert property (take && !hwrite && haddr > 8'h18 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_rsvd_zero: assert property (take && !hwrite && haddr < 8'h0C
    |=> (hrdata & 32'hFFFF_1C2C) == 32'h0) else $error("control reserved bits set");
  a_stat_rsvd_zero: assert property (take && !hwrite && haddr == 8'h0C
    |=> (hrdata & 32'hFFFF_78F8) == 32'h0) else $error("status reserved bits set");
endmodule

bind tcc_top tcc_monitor #(.NCMP(NCMP)) u_mon (
  .hclk                (hclk),
  .hresetn             (hresetn),
  .clk_en              (clk_en),
  .hsel                (hsel),
  .haddr               (haddr),
  .htrans              (htrans),
  .hwrite              (hwrite),
  .hready              (hready),
  .hrdata              (hrdata),
  .hreadyout           (hreadyout),
  .hresp               (hresp),
  .route_sel           (route_sel),
  .internal_ref_source (internal_ref_source),
  .comparator_on       (comparator_on),
  .result_pin          (result_pin),
  .result_pin_oe       (result_pin_oe)
);

//--- tb/triple_comparator_control_tb.sv
// Self-checking bench for the comparator control block
module triple_comparator_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, clk_en, hsel, hwrite, idle_mode;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, rd, d;
  logic [23:0] level;
  wire  [31:0] hrdata;
  wire  [23:0] raw;
  wire  [8:0]  route_sel;
  wire  [2:0]  comparator_on, result_pin, result_pin_oe;
  wire  [1:0]  internal_ref_source;
  wire         hreadyout, hresp, irq;
  int          n_fail, num_checks;

  tcc_top dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .idle_mode(idle_mode), .raw_decision(raw), .route_sel(route_sel),
    .internal_ref_source(internal_ref_source), .comparator_on(comparator_on),
    .result_pin(result_pin), .result_pin_oe(result_pin_oe), .irq(irq));
  tcc_analog_model u_model (.level(level), .raw_decision(raw));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // One single word transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    hsize <= 3'b010;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic stop_test();
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #2000000;
    n_fail++;
    stop_test();
  end

  initial begin
    {hsel, hwrite, idle_mode, hwdata, haddr, htrans, hsize, level} = '0;
    clk_en = 1'b1;
    hresetn = 1'b0;
    tick(2);
    hresetn <= 1'b1;
    for (int i = 0; i < 32; i += 4) rdc(8'(i), 32'h0);
    clk_en <= 1'b0;
    tick(3);
    clk_en <= 1'b1;
    bus(1'b1, 8'h00, 32'hFFFF_DFFF);
    rdc(8'h00, 32'h0000_C0D3);
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
    rdc(8'h1C, 32'h0);
    for (int s = 0; s < 8; s++) begin
      d = 32'hC000 | 32'(s & 3) | 32'((s & 4) << 2);
      bus(1'b1, 8'h04, d);
      level <= 24'h00_0100 << s;
      tick(6);
      chk(32'(route_sel[5:3]), 32'(s));
      chk(32'(result_pin[1] & result_pin_oe[1]), 32'h1);
      rdc(8'h0C, 32'h2);
      bus(1'b1, 8'h04, d | 32'h2000);
      tick(4);
      chk(32'(result_pin[1]), 32'h0);
    end
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 8'h18, 32'(c));
      tick(1);
      chk(32'(internal_ref_source), 32'(c));
    end
    bus(1'b1, 8'h04, 32'h4013);
    tick(1);
    chk(32'({comparator_on[1], result_pin_oe[1], result_pin[1]}), 32'h2);
    bus(1'b1, 8'h04, 32'hC013);
    bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
    chk(32'(comparator_on), 32'h3);
    idle_mode <= 1'b1;
    tick(6);
    chk(32'(result_pin[1]), 32'h0);
    rdc(8'h0C, 32'h8000);
    bus(1'b1, 8'h0C, 32'h0);
    tick(4);
    chk(32'(result_pin[1]), 32'h1);
    idle_mode <= 1'b0;
    bus(1'b1, 8'h14, 32'h4);
    for (int e = 0; e < 4; e++) begin
      bus(1'b1, 8'h08, 32'h8000 | 32'(e << 6));
      bus(1'b1, 8'h10, 32'h7);
      level[16] <= 1'b1;
      tick(6);
      chk(32'(irq), 32'(e & 1));
      rdc(8'h0C, 32'h6 | 32'((e & 1) << 10));
      rdc(8'h08, 32'h8100 | 32'(e << 6) | 32'((e & 1) << 9));
      bus(1'b1, 8'h10, 32'h7);
      level[16] <= 1'b0;
      tick(6);
      chk(32'(irq), 32'(e == 2));
      rdc(8'h0C, 32'h2 | 32'((e != 0) << 10));
    end
    bus(1'b1, 8'h08, 32'h80C0);
    rdc(8'h0C, 32'h2);
    bus(1'b1, 8'h14, 32'h0);
    level[16] <= 1'b1;
    tick(6);
    chk(32'(irq), 32'h0);
    rdc(8'h10, 32'h4);
    bus(1'b1, 8'h14, 32'h4);
    tick(1);
    chk(32'(irq), 32'h1);
    bus(1'b1, 8'h10, 32'h4);
    tick(1);
    chk(32'(irq), 32'h0);
    stop_test();
  end
endmodule
